// [logic/bsq_pin_sync.sv]
// module: three-stage synchronisers for comparator pins
`timescale 1ns/1ps
module bsq_pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  // a change counts only once stages two and three agree; stage one feeds stage two only
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        level[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          level[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : bsq_pin_sync

// [logic/bsq_pkg.sv]
// package: timing, register map and state encoding for the ballast sequencer
package bsq_pkg;
  // the one internal tick is a sixtieth of a millisecond so every factor divides evenly
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SUB_PER_MS = 60;
  localparam int unsigned SUBTICK_CYC = CLK_HZ / 1000 / SUB_PER_MS;
  localparam int unsigned CW = 18;
  // phase durations in milliseconds, as printed
  localparam int unsigned SOFT_START_MS = 10;
  localparam int unsigned PREHEAT_MAX_MS = 2500;
  localparam int unsigned IGNITION_MS = 237;
  localparam int unsigned PRE_RUN_MS = 625;
  localparam int unsigned RECTIFIER_END_OF_LIFE_MS = 2500;
  localparam int unsigned BUS_UV_MS = 800;
  localparam int unsigned RESTART_MS = 200;
  // the same durations as counts of internal ticks
  localparam logic [CW-1:0] SOFT_START_SUB = CW'(SOFT_START_MS * SUB_PER_MS);
  localparam logic [CW-1:0] PREHEAT_MAX_SUB = CW'(PREHEAT_MAX_MS * SUB_PER_MS);
  localparam logic [CW-1:0] IGNITION_SUB = CW'(IGNITION_MS * SUB_PER_MS);
  localparam logic [CW-1:0] PRE_RUN_SUB = CW'(PRE_RUN_MS * SUB_PER_MS);
  localparam logic [CW-1:0] RECTIFIER_END_OF_LIFE_SUB = CW'(RECTIFIER_END_OF_LIFE_MS * SUB_PER_MS);
  localparam logic [CW-1:0] BUS_UV_SUB = CW'(BUS_UV_MS * SUB_PER_MS);
  localparam logic [CW-1:0] RESTART_SUB = CW'(RESTART_MS * SUB_PER_MS);
  // accelerated test mode factors per timed procedure
  localparam logic [CW-1:0] ACC_PREHEAT = 18'h00004;
  localparam logic [CW-1:0] ACC_IGNITION = 18'h00002;
  localparam logic [CW-1:0] ACC_PRE_RUN = 18'h0000f;
  localparam logic [CW-1:0] ACC_RECTIFIER_END_OF_LIFE = 18'h0003c;
  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_IRQ_STS = 5'h08;
  localparam logic [4:0] REG_IRQ_CLR = 5'h0c;
  localparam logic [4:0] REG_IRQ_EN = 5'h10;
  localparam logic CTRL_RST = 1'b1;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam int unsigned NPIN = 31;
  typedef enum logic [3:0] {
    ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF, ST_MONITOR, ST_POWER_UP, ST_START_UP, ST_SOFT_START, ST_PREHEAT,
    ST_IGNITION, ST_PRE_RUN, ST_RUN, ST_BUS_UV, ST_FAULT_WAIT, ST_FAULT_LATCHED
  } bsq_state_t;
endpackage : bsq_pkg

// [logic/bsq_sequencer.sv]
// module: ballast start-up sequencer with test modes, fault handling and register slave
// What this block does
// - bus undervoltage over 800 ms forces lockout
// - supply back above lockout: clear timer, full start
// - phases run monitor through run in order
// - preheat time set by config input, 0-2500ms
// - grounded preheat config skips straight to ignition
// - preheat config high holds preheating
// - grounded filament sense skips that check
// - test mode shortens preheat, ignition, pre-run
// - test mode shortens end-of-life delay by 60
// - test mode armed by supply and test levels
// - low-side sense high blocks power up
// - test mode stays latched once armed
// - one restart after 200 ms fault delay
// - fault latch cleared by lamp removal or lockout
// - bus undervoltage timer cleared entering run
// - pre-run lasts 625 ms before run
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module bsq_sequencer import bsq_pkg::*; #(
  parameter int unsigned TICK_CYC = SUBTICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic supply_above_start,
  input wire logic supply_above_lockout,
  input wire logic bus_under_voltage,
  input wire logic bus_reached_nominal,
  input wire logic preheat_time_cfg_input_gnd,
  input wire logic preheat_time_cfg_input_high,
  input wire logic [11:0] preheat_time_cfg_input_ms,
  input wire logic low_side_filament_sense_gnd,
  input wire logic low_side_filament_sense_high,
  input wire logic low_side_filament_sense_ok,
  input wire logic lamp_volt_sense_single_gnd,
  input wire logic lamp_volt_sense_multi_gnd,
  input wire logic lamp_volt_sense_single_ok,
  input wire logic lamp_volt_sense_multi_ok,
  input wire logic run_frequency_input_test,
  input wire logic preheat_frequency_input_test,
  input wire logic run_frequency_reached,
  input wire logic fault_single_restart,
  input wire logic lamp_removed,
  input wire logic rectifier_end_of_life_cond,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] mode_q,
  output logic pfc_gate_en_q,
  output logic inverter_gate_en_q,
  output logic supply_undervoltage_lockout_q,
  output logic accel_mode_q,
  output logic irq_q
);
  bsq_tick_if tk ();
  logic [NPIN-1:0] pin_lvl;
  logic vcc_start, vcc_ok, bus_uv, bus_ok, ph_gnd, ph_high, lsf_gnd, lsf_high, lsf_ok;
  logic lvss_gnd, lvsm_gnd, lvss_ok, lvsm_ok, rf_test, ph_test, run_freq, flt_evt, lamp_rm, eol_cond;
  logic [11:0] ph_cfg;
  bsq_state_t st_q, st_d;
  logic [CW-1:0] ph_cnt_q, ph_tgt_q, uv_cnt_q, eol_cnt_q, step;
  logic restart_used_q, skip_ph_q, run_en_q, filaments_ok, fault_now;
  logic [3:0] irq_sts_q, irq_en_q, irq_evt, irq_clr;

  // internal tick shared by every timer
  bsq_timebase #(.TICK_CYC(TICK_CYC)) u_tb (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk.src)
  );

  bsq_pin_sync #(.W(NPIN)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({preheat_time_cfg_input_ms, rectifier_end_of_life_cond, lamp_removed, fault_single_restart,
          run_frequency_reached, preheat_frequency_input_test, run_frequency_input_test,
          lamp_volt_sense_multi_ok, lamp_volt_sense_single_ok, lamp_volt_sense_multi_gnd,
          lamp_volt_sense_single_gnd, low_side_filament_sense_ok, low_side_filament_sense_high,
          low_side_filament_sense_gnd, preheat_time_cfg_input_high, preheat_time_cfg_input_gnd,
          bus_reached_nominal, bus_under_voltage, supply_above_lockout, supply_above_start}),
    .level(pin_lvl)
  );

  assign {ph_cfg, eol_cond, lamp_rm, flt_evt, run_freq, ph_test, rf_test, lvsm_ok, lvss_ok, lvsm_gnd,
          lvss_gnd, lsf_ok, lsf_high, lsf_gnd, ph_high, ph_gnd, bus_ok, bus_uv, vcc_ok, vcc_start} = pin_lvl;

  // a grounded sense pin disables its filament check; the board grounds an unused lamp path
  assign filaments_ok = (lsf_gnd | lsf_ok) & (lvss_gnd | lvss_ok) & (lvsm_gnd | lvsm_ok);

  // per-phase advance per tick: test mode scales only through the step size
  always_comb begin
    step = 18'h00001;
    if (accel_mode_q) begin
      unique case (st_q)
        ST_PREHEAT: step = ACC_PREHEAT;
        ST_IGNITION: step = ACC_IGNITION;
        ST_PRE_RUN: step = ACC_PRE_RUN;
        default: step = 18'h00001;
      endcase
    end
  end

  // single-restart class faults: ignition timeout, external fault, rectifier end of life
  assign fault_now = flt_evt || (st_q == ST_IGNITION && ph_cnt_q >= IGNITION_SUB)
                     || (st_q == ST_RUN && eol_cnt_q >= RECTIFIER_END_OF_LIFE_SUB);

  // sequencing through the start-up phases
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF: if (!supply_undervoltage_lockout_q && vcc_ok) st_d = ST_MONITOR;
      ST_MONITOR: if (vcc_start && !lsf_high && filaments_ok && run_en_q) st_d = ST_POWER_UP;
      ST_POWER_UP: if (tk.tick) st_d = ST_START_UP;
      ST_START_UP: if (bus_ok) st_d = ST_SOFT_START;
      ST_SOFT_START: begin
        if (ph_cnt_q >= SOFT_START_SUB) begin
          st_d = (ph_gnd || skip_ph_q) ? ST_IGNITION : ST_PREHEAT;
        end
      end
      ST_PREHEAT: if (!ph_high && ph_cnt_q >= ph_tgt_q) st_d = ST_IGNITION;
      ST_IGNITION: if (run_freq) st_d = ST_PRE_RUN;
      ST_PRE_RUN: if (ph_cnt_q >= PRE_RUN_SUB) st_d = ST_RUN;
      ST_RUN: if (bus_uv) st_d = ST_BUS_UV;
      ST_BUS_UV: begin
        if (uv_cnt_q >= BUS_UV_SUB) st_d = ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF;
        else if (!bus_uv && (lvss_ok || lvsm_ok)) st_d = ST_POWER_UP;
      end
      ST_FAULT_WAIT: if (ph_cnt_q >= RESTART_SUB) st_d = ST_POWER_UP;
      ST_FAULT_LATCHED: if (lamp_rm) st_d = ST_MONITOR;
    endcase
    if (fault_now && st_q inside {[ST_POWER_UP:ST_RUN]}) begin
      st_d = restart_used_q ? ST_FAULT_LATCHED : ST_FAULT_WAIT;
    end
    if (!vcc_ok && st_q != ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF) st_d = ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) st_q <= ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF;
    else st_q <= st_d;
  end

  // phase timer restarts on every state change; preheat target captured during start-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_cnt_q <= '0;
      ph_tgt_q <= '0;
    end else begin
      if (st_d != st_q) ph_cnt_q <= '0;
      else if (tk.tick && ph_cnt_q < PREHEAT_MAX_SUB) ph_cnt_q <= ph_cnt_q + step;
      if (st_q == ST_START_UP) begin
        ph_tgt_q <= (ph_cfg >= 12'(PREHEAT_MAX_MS)) ? PREHEAT_MAX_SUB : CW'(ph_cfg) * CW'(SUB_PER_MS);
      end
    end
  end

  // bus undervoltage duration timer
  always_ff @(posedge aclk) begin
    if (!aresetn) uv_cnt_q <= '0;
    else if ((st_d == ST_RUN && st_q != ST_RUN) || st_q == ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF) uv_cnt_q <= '0;
    else if (st_q == ST_BUS_UV && tk.tick) uv_cnt_q <= uv_cnt_q + 18'h00001;
  end

  // rectifier end-of-life delay, 60 times faster in test mode
  always_ff @(posedge aclk) begin
    if (!aresetn) eol_cnt_q <= '0;
    else if (st_q != ST_RUN || !eol_cond) eol_cnt_q <= '0;
    else if (tk.tick && eol_cnt_q < RECTIFIER_END_OF_LIFE_SUB) eol_cnt_q <= eol_cnt_q + (accel_mode_q ? ACC_RECTIFIER_END_OF_LIFE : 18'h00001);
  end

  // restart bookkeeping: one restart per latch, cleared by lamp removal or lockout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_used_q <= 1'b0;
      skip_ph_q <= 1'b0;
    end else begin
      if (st_d == ST_FAULT_WAIT) restart_used_q <= 1'b1;
      else if (lamp_rm || st_q == ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF) restart_used_q <= 1'b0;
      // a short undervoltage restarts without preheat
      if (st_q == ST_BUS_UV && st_d == ST_POWER_UP) skip_ph_q <= 1'b1;
      else if (st_q == ST_RUN || st_q == ST_MONITOR) skip_ph_q <= 1'b0;
    end
  end

  // lockout forcing holds until the supply has really dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) supply_undervoltage_lockout_q <= 1'b0;
    else if (st_q == ST_BUS_UV && st_d == ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF) supply_undervoltage_lockout_q <= 1'b1;
    else if (!vcc_ok) supply_undervoltage_lockout_q <= 1'b0;
  end

  // test mode armed before power up and kept latched after the test levels go
  always_ff @(posedge aclk) begin
    if (!aresetn) accel_mode_q <= 1'b0;
    else if (st_q == ST_MONITOR && vcc_start && rf_test && ph_test) accel_mode_q <= 1'b1;
  end

  // registered outputs follow the next state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= 4'h0;
      pfc_gate_en_q <= 1'b0;
      inverter_gate_en_q <= 1'b0;
    end else begin
      mode_q <= 4'(st_d);
      pfc_gate_en_q <= st_d inside {[ST_START_UP:ST_RUN]};
      inverter_gate_en_q <= st_d inside {[ST_SOFT_START:ST_RUN]};
    end
  end

  // interrupt status: run reached, fault latched, long undervoltage, test mode armed
  assign irq_evt = {accel_mode_q == 1'b0 && st_q == ST_MONITOR && vcc_start && rf_test && ph_test,
                    st_q == ST_BUS_UV && st_d == ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF,
                    st_d == ST_FAULT_LATCHED && st_q != ST_FAULT_LATCHED,
                    st_d == ST_RUN && st_q != ST_RUN};

  // ---- register slave; write and read channels are independent
  logic aw_hold_q, w_hold_q, wr_go;
  logic [4:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_hit, rd_hit;
  logic [31:0] rd_val;

  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_hit = aw_addr_q inside {REG_CTRL, REG_IRQ_CLR, REG_IRQ_EN};
  assign irq_clr = (wr_go && aw_addr_q == REG_IRQ_CLR && w_strb_q[0]) ? w_data_q[3:0] : 4'h0;

  // address and data are taken in either order and held until both are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_addr_q <= 5'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) aw_hold_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) w_hold_q <= 1'b0;
      s_axi_awready <= !((aw_hold_q && !wr_go) || (s_axi_awvalid && s_axi_awready));
      s_axi_wready <= !((w_hold_q && !wr_go) || (s_axi_wvalid && s_axi_wready));
    end
  end

  // write response; unmapped or read-only offsets answer slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
    end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
  end

  // control and enable registers; only byte lane 0 carries fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_en_q <= CTRL_RST;
      irq_en_q <= IRQ_EN_RST;
    end else if (wr_go && w_strb_q[0]) begin
      if (aw_addr_q == REG_CTRL) run_en_q <= w_data_q[0];
      if (aw_addr_q == REG_IRQ_EN) irq_en_q <= w_data_q[3:0];
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_evt;
      irq_q <= |(((irq_sts_q & ~irq_clr) | irq_evt) & irq_en_q);
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      REG_CTRL: rd_val = {31'h0, run_en_q};
      REG_STATUS: rd_val = {24'h0, supply_undervoltage_lockout_q, skip_ph_q, restart_used_q,
                            accel_mode_q, 4'(st_q)};
      REG_IRQ_STS: rd_val = {28'h0, irq_sts_q};
      REG_IRQ_CLR: rd_val = 32'h0000_0000;
      REG_IRQ_EN: rd_val = {28'h0, irq_en_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // one read at a time; data answered the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
      s_axi_arready <= !((s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready));
    end
  end

  // ---- checks
  bus_uv_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_BUS_UV && uv_cnt_q >= BUS_UV_SUB && vcc_ok |=> st_q == ST_SUPPLY_UNDERVOLTAGE_LOCKOUT_OFF ##0 supply_undervoltage_lockout_q)
    else $error("long bus undervoltage did not force lockout");
  uv_timer_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q == ST_RUN) |-> uv_cnt_q == '0) else $error("undervoltage timer not cleared in run");
  skip_preheat_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_SOFT_START && ph_gnd |=> st_q != ST_PREHEAT) else $error("preheat entered with grounded config");
  preheat_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_PREHEAT && ph_high && vcc_ok && !flt_evt |=> st_q == ST_PREHEAT) else $error("preheat left while held");
  prerun_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q == ST_RUN) |-> $past(st_q) == ST_PRE_RUN && $past(ph_cnt_q) >= PRE_RUN_SUB)
    else $error("run entered without full pre-run");
  no_power_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_MONITOR && lsf_high |=> st_q != ST_POWER_UP) else $error("powered up with low-side sense high");
  accel_arm_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_MONITOR && vcc_start && rf_test && ph_test |=> accel_mode_q) else $error("test mode not armed");
  accel_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    accel_mode_q |=> accel_mode_q [*4]) else $error("test mode dropped");
  accel_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    accel_mode_q && st_q == ST_PRE_RUN && st_d == ST_PRE_RUN && tk.tick |=> ph_cnt_q == $past(ph_cnt_q) + ACC_PRE_RUN)
    else $error("pre-run not accelerated");
  one_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q == ST_FAULT_WAIT) |-> !$past(restart_used_q) ##1 restart_used_q) else $error("second restart");
  fault_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_FAULT_LATCHED && lamp_rm && vcc_ok |=> st_q == ST_MONITOR) else $error("fault latch not cleared");
  reach_run_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(st_q == ST_RUN));
  long_uv_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(supply_undervoltage_lockout_q));
  latched_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(st_q == ST_FAULT_LATCHED));
  accel_run_c: cover property (@(posedge aclk) disable iff (!aresetn) accel_mode_q && st_q == ST_RUN);
endmodule : bsq_sequencer

// [logic/bsq_tick_if.sv]
// interface: internal tick from the timebase to the sequencer
`timescale 1ns/1ps
interface bsq_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface : bsq_tick_if

// [logic/bsq_timebase.sv]
// module: divider producing the one internal tick
`timescale 1ns/1ps
module bsq_timebase import bsq_pkg::*; #(
  parameter int unsigned TICK_CYC = SUBTICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  bsq_tick_if.src tk
);
  logic [15:0] div_q;
  // one-cycle pulse every TICK_CYC clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 16'h0000;
      tk.tick <= 1'b0;
    end else begin
      tk.tick <= (div_q == 16'(TICK_CYC - 1));
      div_q <= (div_q == 16'(TICK_CYC - 1)) ? 16'h0000 : div_q + 16'h0001;
    end
  end
endmodule : bsq_timebase

// [verification/test_bsq_sequencer.sv]
// testbench: registers, test mode arming, accelerated start and fault exit of the sequencer
`timescale 1ns/1ps
module test_bsq_sequencer import bsq_pkg::*;;
  localparam int TC = 4;
  logic aclk, aresetn, supply_above_start, supply_above_lockout, bus_under_voltage, bus_reached_nominal;
  logic preheat_time_cfg_input_gnd, preheat_time_cfg_input_high, low_side_filament_sense_gnd;
  logic low_side_filament_sense_high, low_side_filament_sense_ok, lamp_volt_sense_single_gnd;
  logic lamp_volt_sense_multi_gnd, lamp_volt_sense_single_ok, lamp_volt_sense_multi_ok, run_frequency_input_test;
  logic preheat_frequency_input_test, run_frequency_reached, fault_single_restart, lamp_removed;
  logic rectifier_end_of_life_cond, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] preheat_time_cfg_input_ms;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, mode_q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pfc_gate_en_q, inverter_gate_en_q, supply_undervoltage_lockout_q, accel_mode_q, irq_q;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int t_pre = 0;
  int t_run = 0;
  logic [3:0] seen_q[$];
  logic [3:0] last_mode = 4'h0;

  bsq_sequencer #(.TICK_CYC(TC)) DUT (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // phase recorder: every change of mode_q, with entry times of pre-run and run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (mode_q !== last_mode) begin
      seen_q.push_back(mode_q);
      last_mode <= mode_q;
      if (mode_q === 4'h7) t_pre <= cyc;
      if (mode_q === 4'h8) t_run <= cyc;
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // reset values, an unmapped read and a write to a read-only place
  task automatic test_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(REG_CTRL, d, r);
    chk("ctrl reset", d, 32'h1);
    rd(REG_IRQ_EN, d, r);
    chk("irq_en reset", d, 32'h0);
    rd(5'h14, d, r);
    chk("unmapped rresp", r, 2'h2);
    wr(REG_STATUS, 32'hff, r);
    chk("read-only bresp", r, 2'h2);
  endtask : test_regs

  // test levels with high supply arm the mode; low-side sense high keeps it from powering up
  task automatic test_arm;
    logic [31:0] d;
    logic [1:0] r;
    supply_above_start <= 1'b1;
    run_frequency_input_test <= 1'b1;
    preheat_frequency_input_test <= 1'b1;
    low_side_filament_sense_high <= 1'b1;
    repeat (40) @(posedge aclk);
    chk("accel armed", accel_mode_q, 32'h1);
    run_frequency_input_test <= 1'b0;
    preheat_frequency_input_test <= 1'b0;
    repeat (40) @(posedge aclk);
    chk("accel latched", accel_mode_q, 32'h1);
    chk("held before power up", mode_q, 32'h1);
    chk("gates off", {pfc_gate_en_q, inverter_gate_en_q}, 32'h0);
    chk("irq masked", irq_q, 32'h0);
    wr(REG_IRQ_EN, 32'h8, r);
    repeat (4) @(posedge aclk);
    chk("irq raised", irq_q, 32'h1);
    rd(REG_STATUS, d, r);
    chk("status accel", d[4], 32'h1);
    wr(REG_IRQ_CLR, 32'h8, r);
    repeat (4) @(posedge aclk);
    chk("irq cleared", irq_q, 32'h0);
    rd(REG_IRQ_STS, d, r);
    chk("irq status cleared", d[3], 32'h0);
  endtask : test_arm

  // grounding low-side sense starts the accelerated run, preheat skipped, filament checks off
  task automatic test_accel_start;
    logic [3:0] ex[6] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
    int e;
    int i;
    seen_q.delete();
    preheat_time_cfg_input_gnd <= 1'b1;
    lamp_volt_sense_single_gnd <= 1'b1;
    lamp_volt_sense_multi_gnd <= 1'b1;
    bus_reached_nominal <= 1'b1;
    run_frequency_reached <= 1'b1;
    low_side_filament_sense_high <= 1'b0;
    low_side_filament_sense_gnd <= 1'b1;
    i = 0;
    while (mode_q !== 4'h8 && i < 30000) begin
      @(posedge aclk);
      i++;
    end
    // one more edge so the recorder has logged the run entry and its time
    @(posedge aclk);
    chk("phase count", seen_q.size(), 32'h6);
    for (int k = 0; k < 6; k++) chk("phase order", k < seen_q.size() ? seen_q[k] : 4'hf, ex[k]);
    // pre-run of 625 ms shortened fifteenfold, tick phase may shift it by one tick
    e = int'(PRE_RUN_SUB / ACC_PRE_RUN) * TC;
    chk("pre-run span", (t_run - t_pre >= e - 8) && (t_run - t_pre <= e + 8), 32'h1);
    chk("gates in run", {pfc_gate_en_q, inverter_gate_en_q}, 32'h3);
  endtask : test_accel_start

  // first fault waits for its single restart; lockout clears it; supply back starts over
  task automatic test_fault;
    fault_single_restart <= 1'b1;
    repeat (6) @(posedge aclk);
    fault_single_restart <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("restart wait", mode_q, 32'ha);
    chk("gates off in wait", {pfc_gate_en_q, inverter_gate_en_q}, 32'h0);
    supply_above_lockout <= 1'b0;
    low_side_filament_sense_high <= 1'b1; // keeps the fresh start in monitoring where it can be seen
    repeat (10) @(posedge aclk);
    chk("lockout clears fault", mode_q, 32'h0);
    chk("no forced lockout", supply_undervoltage_lockout_q, 32'h0);
    supply_above_lockout <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("full start again", mode_q, 32'h1);
  endtask : test_fault

  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // watchdog: the whole run needs some 12600 cycles
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    stop_test;
  end

  // main sequence: all inputs defined at time zero, reset held ten cycles
  initial begin
    {aresetn, supply_above_start, bus_under_voltage, bus_reached_nominal, preheat_time_cfg_input_gnd} = '0;
    {preheat_time_cfg_input_high, low_side_filament_sense_gnd, low_side_filament_sense_high} = '0;
    {lamp_volt_sense_single_gnd, lamp_volt_sense_multi_gnd, run_frequency_input_test} = '0;
    {preheat_frequency_input_test, run_frequency_reached, fault_single_restart, lamp_removed} = '0;
    {rectifier_end_of_life_cond, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {low_side_filament_sense_ok, lamp_volt_sense_single_ok, lamp_volt_sense_multi_ok} = 3'h7;
    supply_above_lockout = 1'b1;
    preheat_time_cfg_input_ms = 12'h064;
    s_axi_wstrb = 4'h1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    test_regs;
    test_arm;
    test_accel_start;
    test_fault;
    stop_test;
  end
endmodule : test_bsq_sequencer
